// *** logic/deposit_word_consts.vh ***
// Constants for the deposit word interrupt transfer block.
// Behaviour
// RULE1 - Processor sets function, channel, controller, then raises demand for interrupt address.
// RULE2 - Interface starts the dialogue by asserting the interrupt level zero line.
// RULE3 - On second demand with interrupt address in, drive function word, acknowledge, transfer.
// RULE4 - Function word bits 3 to 5 carry the three-bit service type code.
// RULE5 - Function word bit 6 says whether protection and relocation apply.
// RULE6 - Processor prepares data-in while interface proceeds to assemble the data word.
// RULE7 - Processor stays on the bus until acknowledge and transfer are asserted.
// RULE8 - First data-word state loads the assembly buffer from RAM location 3.
// RULE9 - Second state loads RAM location 2 while shifting the buffer left.
// RULE10 - Afterwards buffer bits 16-19 hold data 00-03, bits 20-35 hold data 04-19.
// RULE11 - Third state loads RAM location 1 while shifting the buffer left again.
// RULE12 - The complete 36-bit word is driven onto the bus data lines.
// RULE13 - Interface asserts acknowledge and transfer; processor later removes demand.
// RULE14 - After demand drops in the final state, release lines and return to idle.
// RULE15 - Each data-word state waits for the previous bus handshake to complete.
`ifndef DEPOSIT_WORD_CONSTS_VH
`define DEPOSIT_WORD_CONSTS_VH
`define FCN_PI_SERVED 3'h1
`define FCN_INTERRUPT_ADDRESS_IN_FUNCTION 3'h2
`define RAM_LOC_WORD1 4'h1
`define RAM_LOC_WORD2 4'h2
`define RAM_LOC_WORD3 4'h3
`define FW_SERVICE_MSB 32
`define FW_SERVICE_LSB 30
`define FW_PROTECT_BIT 29
`define FW_ADDR_MSB 22
`define WORD_RESET 36'h000000000
`endif

// *** logic/word_ram.v ***
// Small word memory with a registered read port for the staged data words.
`timescale 1ns/100ps
module word_ram #(
   parameter WIDTH = 16,
   parameter ADDR_BITS = 4
) (
   input wire clk,
   input wire wr_en,
   input wire [ADDR_BITS-1:0] wr_addr,
   input wire [WIDTH-1:0] wr_data,
   input wire [ADDR_BITS-1:0] rd_addr,
   output reg [WIDTH-1:0] rd_data
);
   reg [WIDTH-1:0] mem [0:(1<<ADDR_BITS)-1];

   // Writes land on the clock; the read word is registered, one cycle behind the address.
   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule

// *** logic/deposit_word_interrupt_transfer.v ***
// Deposit phase: interrupt dialogue, data word assembly and bus handshake.
`timescale 1ns/100ps
`include "deposit_word_consts.vh"
module deposit_word_interrupt_transfer #(
   parameter [2:0] MY_CHANNEL = 3'h1,
   parameter [3:0] MY_CONTROLLER = 4'h0
) (
   input wire clk,
   input wire rstn,
   input wire ram_wr_en,
   input wire [3:0] ram_wr_addr,
   input wire [15:0] ram_wr_data,
   input wire deposit_go,
   input wire [2:0] service_code,
   input wire protect_relocate,
   input wire [22:0] target_address,
   input wire demand,
   input wire [2:0] bus_function,
   input wire [2:0] bus_channel,
   input wire [3:0] bus_controller,
   output reg interrupt_level_zero_line,
   output reg [35:0] data_out,
   output reg data_oe,
   output reg acknowledge,
   output reg transfer,
   output reg busy
);
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_INT_WAIT = 3'h1;
   localparam [2:0] S_FCN_ACK = 3'h2;
   localparam [2:0] S_WORD1 = 3'h3;
   localparam [2:0] S_WORD2 = 3'h4;
   localparam [2:0] S_WORD3 = 3'h5;
   localparam [2:0] S_DATA_WAIT = 3'h6;
   localparam [2:0] S_DATA_ACK = 3'h7;

   reg [2:0] state;
   reg [2:0] next_state;
   reg phase;
   reg next_phase;
   reg demand_q;
   reg seen_first;
   reg next_seen_first;
   reg [35:0] assembly;
   reg [35:0] next_assembly;
   reg [3:0] rd_addr;
   reg [3:0] next_rd_addr;
   reg next_int_line;
   reg [35:0] next_data_out;
   reg next_data_oe;
   reg next_handshake;
   wire [15:0] rd_data;
   wire demand_rise;

   // Builds the interrupt function word from the service request inputs.
   function [35:0] make_function_word;
      input [2:0] svc;
      input prot;
      input [22:0] addr;
      reg [35:0] w;
      begin
         w = `WORD_RESET;
         w[`FW_SERVICE_MSB:`FW_SERVICE_LSB] = svc; // [RULE4]
         w[`FW_PROTECT_BIT] = prot; // [RULE5]
         w[`FW_ADDR_MSB:0] = addr;
         make_function_word = w;
      end
   endfunction

   // Staging memory for the three 16-bit pieces of the data word.
   word_ram #(
      .WIDTH(16),
      .ADDR_BITS(4)
   ) u_ram (
      .clk(clk),
      .wr_en(ram_wr_en),
      .wr_addr(ram_wr_addr),
      .wr_data(ram_wr_data),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

   assign demand_rise = demand & ~demand_q;

   // Next-state logic of the deposit sequencer.
   always @* begin
      next_state = state;
      next_phase = phase;
      next_seen_first = seen_first;
      next_assembly = assembly;
      next_rd_addr = rd_addr;
      next_int_line = interrupt_level_zero_line;
      next_data_out = data_out;
      next_data_oe = data_oe;
      next_handshake = acknowledge;
      case (state)
         S_IDLE: begin
            if (deposit_go) begin
               next_int_line = 1'b1; // [RULE2]
               next_seen_first = 1'b0;
               next_state = S_INT_WAIT;
            end
         end
         S_INT_WAIT: begin
            // The processor names function, channel and controller before demand rises. [RULE1]
            if (demand_rise && bus_channel == MY_CHANNEL) begin
               if (seen_first && bus_function == `FCN_INTERRUPT_ADDRESS_IN_FUNCTION && bus_controller == MY_CONTROLLER) begin
                  next_data_out = make_function_word(service_code, protect_relocate, target_address); // [RULE3]
                  next_data_oe = 1'b1;
                  next_handshake = 1'b1;
                  next_rd_addr = `RAM_LOC_WORD3;
                  next_state = S_FCN_ACK;
               end else begin
                  next_seen_first = 1'b1;
               end
            end
         end
         S_FCN_ACK: begin
            // The processor holds the bus until the handshake is seen, then drops demand. [RULE7]
            if (!demand) begin
               next_int_line = 1'b0;
               next_data_oe = 1'b0;
               next_data_out = `WORD_RESET;
               next_handshake = 1'b0;
               next_phase = 1'b0;
               next_state = S_WORD1; // [RULE6]
            end
         end
         S_WORD1: begin
            // Phase 0 waits out the registered read; phase 1 loads the word. [RULE15]
            next_phase = ~phase;
            if (phase) begin
               next_assembly = {20'h00000, rd_data}; // [RULE8]
               next_rd_addr = `RAM_LOC_WORD2;
               next_state = S_WORD2;
            end
         end
         S_WORD2: begin
            next_phase = ~phase;
            if (phase) begin
               // Shift left while loading; bits 16-19 now hold data 00-03. [RULE9] [RULE10]
               next_assembly = {assembly[19:0], rd_data};
               next_rd_addr = `RAM_LOC_WORD1;
               next_state = S_WORD3;
            end
         end
         S_WORD3: begin
            next_phase = ~phase;
            if (phase) begin
               next_assembly = {assembly[19:0], rd_data}; // [RULE11]
               next_state = S_DATA_WAIT;
            end
         end
         S_DATA_WAIT: begin
            // The data-in demand must come after the previous demand has dropped. [RULE15]
            if (demand_rise) begin
               next_data_out = assembly; // [RULE12]
               next_data_oe = 1'b1;
               next_handshake = 1'b1; // [RULE13]
               next_state = S_DATA_ACK;
            end
         end
         S_DATA_ACK: begin
            if (!demand) begin
               next_data_oe = 1'b0; // [RULE14]
               next_data_out = `WORD_RESET;
               next_handshake = 1'b0;
               next_state = S_IDLE;
            end
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   // State and output registers.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= S_IDLE;
         phase <= 1'b0;
         demand_q <= 1'b0;
         seen_first <= 1'b0;
         assembly <= `WORD_RESET;
         rd_addr <= 4'h0;
         interrupt_level_zero_line <= 1'b0;
         data_out <= `WORD_RESET;
         data_oe <= 1'b0;
         acknowledge <= 1'b0;
         transfer <= 1'b0;
         busy <= 1'b0;
      end else begin
         state <= next_state;
         phase <= next_phase;
         demand_q <= demand;
         seen_first <= next_seen_first;
         assembly <= next_assembly;
         rd_addr <= next_rd_addr;
         interrupt_level_zero_line <= next_int_line;
         data_out <= next_data_out;
         data_oe <= next_data_oe;
         acknowledge <= next_handshake; // [RULE3] [RULE13]
         transfer <= next_handshake;
         busy <= (next_state != S_IDLE);
      end
   end
endmodule

// *** test/deposit_word_props.sv ***
// Port checker for the deposit transfer block.
`timescale 1ns/100ps
module deposit_word_props (
   input wire clk,
   input wire rstn,
   input wire deposit_go,
   input wire [2:0] service_code,
   input wire protect_relocate,
   input wire demand,
   input wire interrupt_level_zero_line,
   input wire [35:0] data_out,
   input wire data_oe,
   input wire acknowledge,
   input wire transfer,
   input wire busy
);
   // All checks share the one clock and reset.
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   int_line_a: assert property (deposit_go && !busy |=> interrupt_level_zero_line && busy)
      else $error("interrupt line not raised");
   hs_pair_a: assert property (acknowledge |-> transfer && data_oe)
      else $error("handshake lines split");
   ack_cause_a: assert property ($rose(acknowledge) |-> $past(demand) && !$past(demand, 2))
      else $error("acknowledge without demand rise");
   fn_fields_a: assert property ($rose(acknowledge) && interrupt_level_zero_line |->
      data_out[32:29] == $past({service_code, protect_relocate})) else $error("function word fields");
   hold_data_a: assert property (acknowledge && demand |=> acknowledge && $stable(data_out))
      else $error("data not held");
   line_release_a: assert property (acknowledge && !demand |=> !acknowledge && !data_oe && data_out == 36'h0)
      else $error("lines not released");
   asm_gap_a: assert property ($fell(interrupt_level_zero_line) |-> (busy && !acknowledge) [*6])
      else $error("assembly states skipped");
   idle_quiet_a: assert property (!busy |-> !acknowledge && !data_oe && !interrupt_level_zero_line)
      else $error("outputs active in idle");
   cover property ($rose(acknowledge) && interrupt_level_zero_line);
   cover property ($rose(acknowledge) && !interrupt_level_zero_line);
   cover property ($fell(busy));
endmodule
bind deposit_word_interrupt_transfer deposit_word_props i_props (.clk(clk), .rstn(rstn), .deposit_go(deposit_go),
   .service_code(service_code), .protect_relocate(protect_relocate), .demand(demand),
   .interrupt_level_zero_line(interrupt_level_zero_line), .data_out(data_out), .data_oe(data_oe),
   .acknowledge(acknowledge), .transfer(transfer), .busy(busy));

// *** test/cpu_model.sv ***
// Processor-side model on the I/O bus.
`timescale 1ns/100ps
module cpu_model (
   input wire clk,
   input wire acknowledge,
   output reg demand,
   output reg [2:0] bus_function,
   output reg [2:0] bus_channel,
   output reg [3:0] bus_controller
);
   // Idle lines start away from any value the block accepts.
   initial begin
      demand = 1'b0;
      bus_function = 3'h7;
      bus_channel = 3'h6;
      bus_controller = 4'hF;
   end
   // Lines settle first, then demand; held until answered or a short span, then inverted.
   task request(input [2:0] fcn, input ans, input integer slow);
      integer n;
      begin
         @(negedge clk);
         bus_function = fcn;
         bus_channel = 3'h1;
         bus_controller = 4'h0;
         repeat (slow + 1) @(negedge clk);
         demand = 1'b1;
         n = 0;
         while ((ans && !acknowledge && n < 40) || (!ans && n < 3)) begin
            @(negedge clk);
            n = n + 1;
         end
         // Demand may linger a few cycles after the answer before it is removed.
         repeat (slow % 3) @(negedge clk);
         demand = 1'b0;
         bus_function = ~bus_function;
         bus_channel = ~bus_channel;
         bus_controller = ~bus_controller;
      end
   endtask
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the deposit transfer block.
`timescale 1ns/100ps
module testbench;
   reg clk, rstn, ram_wr_en, deposit_go, protect_relocate, ack_q;
   reg [3:0] ram_wr_addr;
   reg [15:0] ram_wr_data;
   reg [2:0] service_code;
   reg [22:0] target_address;
   reg [35:0] word;
   reg [31:0] rnd;
   reg [35:0] exp_q[$];
   reg [35:0] mask_q[$];
   wire demand, interrupt_level_zero_line, data_oe, acknowledge, transfer, busy;
   wire [2:0] bus_function, bus_channel;
   wire [3:0] bus_controller;
   wire [35:0] data_out;
   integer seed, bad_count, cmp_count, cycles, i;
   deposit_word_interrupt_transfer i_dut (.clk(clk), .rstn(rstn), .ram_wr_en(ram_wr_en),
      .ram_wr_addr(ram_wr_addr), .ram_wr_data(ram_wr_data), .deposit_go(deposit_go),
      .service_code(service_code), .protect_relocate(protect_relocate), .target_address(target_address),
      .demand(demand), .bus_function(bus_function), .bus_channel(bus_channel),
      .bus_controller(bus_controller), .interrupt_level_zero_line(interrupt_level_zero_line),
      .data_out(data_out), .data_oe(data_oe), .acknowledge(acknowledge), .transfer(transfer), .busy(busy));
   cpu_model u_cpu (.clk(clk), .acknowledge(acknowledge), .demand(demand), .bus_function(bus_function),
      .bus_channel(bus_channel), .bus_controller(bus_controller));
   task check(input [35:0] seen, input [35:0] want);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== want) begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
         end
      end
   endtask
   task tally_and_finish;
      begin
         $display("compares %0d mismatches %0d", cmp_count, bad_count);
         if (bad_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // The strobe stays up across back-to-back writes; the caller lowers it after the last one.
   task wr(input [3:0] a, input [15:0] d);
      begin
         ram_wr_en = 1'b1;
         ram_wr_addr = a;
         ram_wr_data = d;
         @(negedge clk);
      end
   endtask
   // Clock and cycle limit.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 3000) begin
         bad_count = bad_count + 1;
         tally_and_finish;
      end
   end
   // Each answered demand takes the oldest expected word.
   always @(negedge clk) begin
      if (acknowledge && !ack_q) begin
         check(data_out & mask_q[0], exp_q[0]);
         check({34'h0, data_oe, transfer}, 36'h3);
         exp_q.pop_front();
         mask_q.pop_front();
      end
      ack_q = acknowledge;
   end
   // Three deposits with random pieces and a stray start while busy.
   initial begin
      {rstn, ram_wr_en, deposit_go, ram_wr_addr, ram_wr_data} = 23'h0;
      {service_code, protect_relocate, target_address} = 27'h0;
      seed = 32'hC435;
      bad_count = 0;
      cmp_count = 0;
      cycles = 0;
      repeat (12) @(negedge clk);
      rstn = 1'b1;
      for (i = 0; i < 3; i = i + 1) begin
         rnd = $random(seed);
         word[35:4] = rnd;
         rnd = $random(seed);
         word[3:0] = rnd[3:0];
         wr(4'h3, {12'h000, word[35:32]});
         wr(4'h2, word[31:16]);
         wr(4'h1, word[15:0]);
         ram_wr_en = 1'b0;
         rnd = $random(seed);
         service_code = rnd[2:0];
         protect_relocate = rnd[3];
         target_address = rnd[31:9];
         exp_q.push_back({3'h0, service_code, protect_relocate, 6'h00, target_address});
         mask_q.push_back(36'h1E07FFFFF);
         exp_q.push_back(word);
         mask_q.push_back(36'hFFFFFFFFF);
         deposit_go = 1'b1;
         @(negedge clk);
         deposit_go = i == 1;
         @(negedge clk);
         deposit_go = 1'b0;
         check({35'h0, interrupt_level_zero_line}, 36'h1);
         u_cpu.request(3'h1, 1'b0, i);
         u_cpu.request(3'h2, 1'b1, 2 * i);
         u_cpu.request(3'h5, 1'b1, 8 + i);
         repeat (2) @(negedge clk);
         check({35'h0, busy}, 36'h0);
         check(data_out, 36'h0);
         check({35'h0, interrupt_level_zero_line}, 36'h0);
         $display("deposit %0d done", i);
      end
      check({35'h0, exp_q.size() == 0}, 36'h1);
      tally_and_finish;
   end
endmodule
